// [logic/led_driver_pkg.sv]
// Summary of operation
// - drive stays on until debounced sense reaches peak threshold, then off.
// - after peak, drive held off for counter-timed off interval, then on.
// - sense comparator result debounced about one microsecond before use.
// - switching runs only while light enable high; otherwise drive off.
// - jitter bit set XORs pseudo-random value into low three off-time bits.
// - random generator steps once per off period, from off-time timing.
// - configuration bit 19 selects internal (1) or external temperature sensor.
// - configuration bit 18 is jitter enable, one enables random off time.
// - configuration bits 17:15 select delay after reset before switching.
// - configuration bits 14:10 hold five-bit temperature shut-off threshold.
// - configuration bits 9:4 hold six-bit off-time setting.
// - configuration bits 3:0 hold four-bit peak current threshold.
// - configuration word held in non-volatile latch, written when programming.
package led_driver_pkg;
  localparam int cfg_w = 20;
  localparam int sensor_sel_bit = 19;
  localparam int jitter_bit = 18;
  localparam int por_hi = 17;
  localparam int por_lo = 15;
  localparam int temp_hi = 14;
  localparam int temp_lo = 10;
  localparam int off_hi = 9;
  localparam int off_lo = 4;
  localparam int peak_hi = 3;
  localparam int peak_lo = 0;
  localparam int clk_mhz = 20;
  localparam int debounce_ns = 1000;
  localparam int debounce_cyc = (debounce_ns * clk_mhz) / 1000;
  localparam logic [4:0] debounce_max = 5'(debounce_cyc - 1);
  localparam int off_unit_cyc = 4;
  localparam int por_unit_cyc = 4096;
  localparam logic [2:0] lfsr_seed = 3'h1;
  localparam logic [cfg_w-1:0] cfg_reset = 20'h00000;
  typedef enum logic [3:0] {
    st_delay = 4'h1,
    st_idle = 4'h2,
    st_on = 4'h4,
    st_off = 4'h8
  } state_type;
endpackage

// [logic/sense_debounce.sv]
`timescale 1ns/100ps
module sense_debounce (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic raw_in,
  output logic clean_out
);
  logic [4:0] cnt_q;
  logic clean_q;
  // only a high held for the full window counts; release is immediate
  // so short off times are not stretched by the filter
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      cnt_q <= 5'h00;
      clean_q <= 1'b0;
    end
    else if (!raw_in)
    begin
      cnt_q <= 5'h00;
      clean_q <= 1'b0;
    end
    else if (clean_q)
    begin
      cnt_q <= 5'h00;
    end
    else if (cnt_q == led_driver_pkg::debounce_max)
    begin
      cnt_q <= 5'h00;
      clean_q <= raw_in;
    end
    else
    begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  assign clean_out = clean_q;
endmodule

// [logic/peak_current_offtime_led_driver.sv]
`timescale 1ns/100ps
module peak_current_offtime_led_driver #(
  parameter int por_unit = led_driver_pkg::por_unit_cyc
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic light_enable_input,
  input wire logic current_sense_pin,
  input wire logic temp_internal_over,
  input wire logic temp_external_over,
  input wire logic prog_write,
  input wire logic [19:0] prog_data,
  output logic [19:0] cfg_word,
  output logic [4:0] temp_threshold,
  output logic [3:0] peak_threshold,
  output logic temp_sensor_internal,
  output logic drive_out,
  output logic [5:0] eff_off_time
);
  logic [19:0] cfg_q;
  logic sense_clean;
  led_driver_pkg::state_type state_q;
  logic [5:0] off_cnt_q;
  logic [1:0] unit_q;
  logic [2:0] lfsr_q;
  logic [15:0] por_cnt_q;
  logic drive_q;
  logic [5:0] off_eff;
  logic over_temp;
  logic [2:0] por_sel;
  logic [15:0] por_target;

  // non-volatile: reset leaves it alone, only a programming strobe loads it
  always_ff @(posedge sys_clk)
  begin
    if (prog_write)
      cfg_q <= prog_data;
  end

  sense_debounce u_deb (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .raw_in(current_sense_pin),
    .clean_out(sense_clean)
  );

  assign temp_sensor_internal = cfg_q[led_driver_pkg::sensor_sel_bit];
  assign over_temp = temp_sensor_internal ? temp_internal_over
                                          : temp_external_over;
  assign temp_threshold =
    cfg_q[led_driver_pkg::temp_hi:led_driver_pkg::temp_lo];
  assign peak_threshold =
    cfg_q[led_driver_pkg::peak_hi:led_driver_pkg::peak_lo];
  assign por_sel = cfg_q[led_driver_pkg::por_hi:led_driver_pkg::por_lo];
  assign por_target = 16'(por_sel) * 16'(por_unit);
  assign off_eff = cfg_q[led_driver_pkg::jitter_bit]
    ? {cfg_q[led_driver_pkg::off_hi:led_driver_pkg::off_lo+3],
       cfg_q[led_driver_pkg::off_lo+2:led_driver_pkg::off_lo] ^ lfsr_q}
    : cfg_q[led_driver_pkg::off_hi:led_driver_pkg::off_lo];

  // post-reset delay counter
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      por_cnt_q <= 16'h0000;
    else if (state_q == led_driver_pkg::st_delay)
      por_cnt_q <= por_cnt_q + 16'h0001;
  end

  // off-time prescaler and compare counter
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || state_q != led_driver_pkg::st_off)
    begin
      unit_q <= 2'h0;
      off_cnt_q <= 6'h00;
    end
    else
    begin
      unit_q <= unit_q + 2'h1;
      if (unit_q == 2'(led_driver_pkg::off_unit_cyc - 1))
        off_cnt_q <= off_cnt_q + 6'h01;
    end
  end

  // lfsr steps at each off-period end; never all zero
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      lfsr_q <= led_driver_pkg::lfsr_seed;
    else if (state_q == led_driver_pkg::st_off && off_cnt_q >= off_eff)
      lfsr_q <= {lfsr_q[1:0], lfsr_q[2] ^ lfsr_q[1]};
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      state_q <= led_driver_pkg::st_delay;
    else
    begin
      case (state_q)
        led_driver_pkg::st_delay:
          if (por_cnt_q >= por_target)
            state_q <= led_driver_pkg::st_idle;
        led_driver_pkg::st_idle:
          if (light_enable_input && !over_temp)
            state_q <= led_driver_pkg::st_on;
        led_driver_pkg::st_on:
          if (!light_enable_input || over_temp)
            state_q <= led_driver_pkg::st_idle;
          else if (sense_clean)
            state_q <= led_driver_pkg::st_off;
        led_driver_pkg::st_off:
          if (!light_enable_input || over_temp)
            state_q <= led_driver_pkg::st_idle;
          else if (off_cnt_q >= off_eff)
            state_q <= led_driver_pkg::st_on;
        default:
          state_q <= led_driver_pkg::st_idle;
      endcase
    end
  end

  // registered drive: on in on and idle phases and at off-phase end, gated by enable, over-temperature and sense
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      drive_q <= 1'b0;
    else
      drive_q <= light_enable_input && !over_temp && !sense_clean &&
        (state_q == led_driver_pkg::st_on ||
         (state_q == led_driver_pkg::st_idle) ||
         (state_q == led_driver_pkg::st_off && off_cnt_q >= off_eff));
  end

  assign drive_out = drive_q;
  assign cfg_word = cfg_q;
  assign eff_off_time = off_eff;
endmodule

// [verification/led_driver_checker.sv]
`timescale 1ns/100ps
module led_driver_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic light_enable_input,
  input wire logic current_sense_pin,
  input wire logic temp_internal_over,
  input wire logic temp_external_over,
  input wire logic prog_write,
  input wire logic [19:0] prog_data,
  input wire logic [19:0] cfg_word,
  input wire logic [4:0] temp_threshold,
  input wire logic [3:0] peak_threshold,
  input wire logic temp_sensor_internal,
  input wire logic drive_out,
  input wire logic [5:0] eff_off_time
);
  logic ovr;
  assign ovr = temp_sensor_internal ? temp_internal_over : temp_external_over;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence peak_end;
    $fell(drive_out) && $past(light_enable_input) && !$past(ovr);
  endsequence
  sequence off_hold;
    !drive_out [*3];
  endsequence
  a_sense_held_off: assert property (
    peak_end |-> $past(current_sense_pin, 8))
    else $error("drive fell without held sense");
  a_off_min_hold: assert property (peak_end |-> off_hold)
    else $error("off phase too short");
  a_enable_gate: assert property (!light_enable_input [*2] |-> !drive_out)
    else $error("drive on while disabled");
  a_temp_gate: assert property (ovr [*2] |-> !drive_out)
    else $error("drive on while over temperature");
  a_prog_load: assert property (prog_write |=> cfg_word == $past(prog_data))
    else $error("config not loaded");
  a_latch_hold: assert property (!prog_write |=> $stable(cfg_word))
    else $error("config changed without write");
  a_field_map: assert property (peak_threshold == cfg_word[3:0] &&
    temp_threshold == cfg_word[14:10] && temp_sensor_internal == cfg_word[19])
    else $error("config field mismatch");
  a_off_plain: assert property (
    !cfg_word[18] |-> eff_off_time == cfg_word[9:4])
    else $error("off time altered without jitter");
  a_jitter_high: assert property (eff_off_time[5:3] == cfg_word[9:7])
    else $error("jitter touched upper bits");
endmodule
bind peak_current_offtime_led_driver led_driver_checker u_led_driver_checker (.*);

// [verification/led_power_stage.sv]
`timescale 1ns/100ps
module led_power_stage (
  input wire logic sys_clk,
  input wire logic drive_out,
  input wire logic ring,
  output logic current_sense_pin
);
  int cnt = 0;
  always @(posedge sys_clk) cnt <= drive_out ? cnt + 1 : 0;
  // ringing spike shortly after turn-on, shorter than the debounce time
  assign current_sense_pin = cnt >= 40 || (ring && cnt inside {[2:10]});
endmodule

// [verification/peak_current_offtime_led_driver_bench.sv]
`timescale 1ns/100ps
module peak_current_offtime_led_driver_bench;
  logic sys_clk = 0, rstn = 0, light_enable_input = 0, ring = 0;
  logic temp_internal_over = 0, temp_external_over = 0, prog_write = 0;
  logic [19:0] prog_data = 20'h00000, cfg_word;
  logic [4:0] temp_threshold;
  logic [3:0] peak_threshold;
  logic temp_sensor_internal, drive_out, current_sense_pin;
  logic [5:0] eff_off_time, e0;
  int error_cnt = 0, total_checks = 0, n, o;
  peak_current_offtime_led_driver #(.por_unit(8))
    u_peak_current_offtime_led_driver (.*);
  led_power_stage u_led_power_stage (.*);
  initial forever #25 sys_clk = ~sys_clk;
  task complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input bit ok);
    total_checks++;
    if (!ok)
    begin
      error_cnt++;
      $display("mismatch at %0t check %0d", $time, total_checks);
    end
  endtask
  // counts edges until drive reaches lv; bounded so a hang ends the run
  task run_to(input logic lv);
    n = 0;
    while (drive_out !== lv)
    begin
      @(posedge sys_clk);
      #1 n++;
      if (n > 3000)
      begin
        chk(0);
        complete_run;
      end
    end
  endtask
  task prog(input logic [19:0] d);
    @(posedge sys_clk);
    prog_data <= d;
    prog_write <= 1'b1;
    @(posedge sys_clk);
    prog_write <= 1'b0;
    #1 chk(cfg_word === d);
  endtask
  initial
  begin
    ring <= 1'b1;
    repeat (1) @(posedge sys_clk);
    prog(20'h3800f);
    @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rstn <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b1;
    light_enable_input <= 1'b1;
    run_to(1'b1);
    chk(n >= 50);
    for (o = 0; o < 64; o += 63)
    begin
      prog(20'h0000f | (o << 4));
      run_to(1'b0);
      run_to(1'b1);
      run_to(1'b0);
      chk(n >= 40);
      run_to(1'b1);
      chk(n >= o * 4 + 1 && n <= o * 4 + 12);
    end
    prog(20'h403f0);
    run_to(1'b0);
    e0 = eff_off_time;
    run_to(1'b1);
    run_to(1'b0);
    chk(eff_off_time !== e0 && eff_off_time[5:3] === 3'h7);
    prog(20'h803f0);
    temp_internal_over <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk(drive_out === 1'b0);
    temp_internal_over <= 1'b0;
    light_enable_input <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk(drive_out === 1'b0);
    complete_run;
  end
endmodule
